// ==== common/slur_pkg.sv ====
/*
 holds register map, field layout, reset values and encodings of the led, unknown-da,
 drive strength and station address bank.
 assumes a 32-bit axi4-lite master and a 100 MHz core clock.
*/
package slur_pkg;
    // ----------------------------------------------------------------
    // register offsets (word indices, times four for the byte addresses below)
    // ----------------------------------------------------------------
    localparam int IDX_CTRL = 'h00e;
    localparam int IDX_MAC_HI = 'h010;
    localparam int IDX_MAC_MID = 'h012;
    localparam int IDX_MAC_LO = 'h014;
    localparam logic [11:0] ADDR_CTRL = 12'(IDX_CTRL * 4);
    localparam logic [11:0] ADDR_MAC_HI = 12'(IDX_MAC_HI * 4);
    localparam logic [11:0] ADDR_MAC_MID = 12'(IDX_MAC_MID * 4);
    localparam logic [11:0] ADDR_MAC_LO = 12'(IDX_MAC_LO * 4);
    localparam int ADDR_W = 12;
    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int LED_MODE_LSB = 8;
    localparam int UNK_EN_BIT = 7;
    localparam int DRIVE_LSB = 5;
    localparam int UNK_MASK_LSB = 0;
    localparam logic [15:0] CTRL_RW_MASK = 16'hffff;
    localparam logic [5:0] CTRL_RSVD_HI_RESET = 6'h02;
    localparam logic [1:0] LED_MODE_RESET = 2'h0;
    localparam logic UNK_EN_RESET = 1'b0;
    localparam logic [2:0] UNK_MASK_RESET = 3'h7;
    localparam logic [1:0] DRIVE_RESET_HIGH_IO = 2'h1;
    localparam logic [1:0] DRIVE_RESET_LOW_IO = 2'h2;
    localparam logic [1:0] CTRL_RSVD_LO_RESET = 2'h0;
    // ----------------------------------------------------------------
    // station address resets; hi and mid are arbitrary values
    // ----------------------------------------------------------------
    localparam logic [15:0] MAC_HI_RESET = 16'h0000;
    localparam logic [15:0] MAC_MID_RESET = 16'h0000;
    localparam logic [15:0] MAC_LO_RESET = 16'hffff;
    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        LED_SPEED_LINKACT = 2'b00,
        LED_ACT_LINK = 2'b01,
        LED_FDX_LINKACT = 2'b10,
        LED_FDX_LINK = 2'b11
    } slur_led_mode_t;
    typedef enum logic [1:0]
    {
        DRV_4MA = 2'b00,
        DRV_8MA = 2'b01,
        DRV_12MA = 2'b10,
        DRV_16MA = 2'b11
    } slur_drive_t;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    localparam int NUM_PORTS = 3;
endpackage : slur_pkg

// ==== common/slur_cfg_if.sv ====
/*
 holds the configuration carrier from the register bank to its consumers.
 assumes one clock domain; bank drives, consumers read.
*/
`timescale 1ns/1ps
interface slur_cfg_if;
    logic [1:0] led_mode;
    logic unk_en;
    logic [2:0] unk_mask;
    logic [1:0] drive;
    logic [47:0] station_address_field;
    modport bank
    (
        output led_mode,
        output unk_en,
        output unk_mask,
        output drive,
        output station_address_field
    );
    modport user
    (
        input led_mode,
        input unk_en,
        input unk_mask,
        input drive,
        input station_address_field
    );
endinterface : slur_cfg_if

// ==== verilog/slur_led_mux.sv ====
/*
 holds the per-port led selection from link, speed, duplex and activity status.
 assumes status inputs are already on aclk.
*/
`timescale 1ns/1ps
module slur_led_mux
(
    input wire logic aclk,
    input wire logic aresetn,
    slur_cfg_if.user cfg,
    input wire logic [1:0] link_up,
    input wire logic [1:0] speed_100,
    input wire logic [1:0] full_duplex,
    input wire logic [1:0] activity,
    output logic [1:0] port_led_secondary_out,
    output logic [1:0] port_led_primary_out
);
    logic [1:0] next_sec;
    logic [1:0] next_pri;
    always_comb
    begin
        next_sec = '0;
        next_pri = '0;
        for (int p = 0; p < 2; p++)
        begin
            case (slur_pkg::slur_led_mode_t'(cfg.led_mode))
                slur_pkg::LED_SPEED_LINKACT:
                begin
                    next_sec[p] = speed_100[p];
                    next_pri[p] = link_up[p] & ~activity[p];
                end
                slur_pkg::LED_ACT_LINK:
                begin
                    next_sec[p] = activity[p];
                    next_pri[p] = link_up[p];
                end
                slur_pkg::LED_FDX_LINKACT:
                begin
                    next_sec[p] = full_duplex[p];
                    next_pri[p] = link_up[p] & ~activity[p];
                end
                default:
                begin
                    next_sec[p] = full_duplex[p];
                    next_pri[p] = link_up[p];
                end
            endcase
        end
    end
    // link-and-activity blinks off while traffic flows
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_led_secondary_out <= '0;
            port_led_primary_out <= '0;
        end
        else
        begin
            port_led_secondary_out <= next_sec;
            port_led_primary_out <= next_pri;
        end
    end
endmodule : slur_led_mux

// ==== verilog/slur_fwd_pause.sv ====
/*
 holds unknown-da destination selection, pin drive selection and pause source address.
 assumes lookup_miss and pause_req are single-cycle pulses on aclk.
*/
`timescale 1ns/1ps
module slur_fwd_pause
(
    input wire logic aclk,
    input wire logic aresetn,
    slur_cfg_if.user cfg,
    input wire logic lookup_miss,
    input wire logic pause_req,
    output logic [2:0] unknown_fwd_ports,
    output logic unknown_fwd_valid,
    output logic [47:0] pause_source_address,
    output logic pause_valid,
    output logic [1:0] gpio_drive_sel
);
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            unknown_fwd_ports <= '0;
            unknown_fwd_valid <= 1'b0;
        end
        else
        begin
            unknown_fwd_valid <= lookup_miss;
            unknown_fwd_ports <= cfg.unk_en ? cfg.unk_mask : 3'h0;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pause_source_address <= '0;
            pause_valid <= 1'b0;
        end
        else
        begin
            pause_valid <= pause_req;
            if (pause_req)
            begin
                pause_source_address <= cfg.station_address_field;
            end
        end
    end
    // led, irq and reset pins carry no drive select at all
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            gpio_drive_sel <= slur_pkg::DRIVE_RESET_HIGH_IO;
        end
        else
        begin
            gpio_drive_sel <= cfg.drive;
        end
    end
endmodule : slur_fwd_pause

// ==== verilog/slur_regs.sv ====
/*
 holds the axi4-lite register bank for led mode, unknown-da forwarding, drive strength
 and the station address, plus its two consumers.
 assumes a single 100 MHz clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module slur_regs
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic io_supply_low,
    input wire logic [1:0] link_up,
    input wire logic [1:0] speed_100,
    input wire logic [1:0] full_duplex,
    input wire logic [1:0] activity,
    input wire logic lookup_miss,
    input wire logic pause_req,
    output logic [1:0] port_led_secondary_out,
    output logic [1:0] port_led_primary_out,
    output logic [2:0] unknown_fwd_ports,
    output logic unknown_fwd_valid,
    output logic [47:0] pause_source_address,
    output logic pause_valid,
    output logic [1:0] gpio_drive_sel
);
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic [2:0] reg_sel(input logic [11:0] addr);
        case (addr)
            slur_pkg::ADDR_CTRL: reg_sel = 3'h1;
            slur_pkg::ADDR_MAC_HI: reg_sel = 3'h2;
            slur_pkg::ADDR_MAC_MID: reg_sel = 3'h3;
            slur_pkg::ADDR_MAC_LO: reg_sel = 3'h4;
            default: reg_sel = 3'h0;
        endcase
    endfunction : reg_sel

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
        input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    slur_cfg_if cfg ();

    // ----------------------------------------------------------------
    // supply strap, two flops then caught once after reset release
    // ----------------------------------------------------------------
    logic strap_meta;
    logic strap_sync;
    logic strap_done;
    always_ff @(posedge aclk)
    begin
        strap_meta <= io_supply_low;
        strap_sync <= strap_meta;
    end

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [15:0] ctrl;
    logic [15:0] mac_hi;
    logic [15:0] mac_mid;
    logic [15:0] mac_lo;

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [2:0] wsel;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wsel = reg_sel(aw_addr);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
            begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= slur_pkg::AXI_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == 3'h0) ? slur_pkg::AXI_SLVERR : slur_pkg::AXI_OKAY;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control register; drive field reloads from strap once after reset
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl <= {slur_pkg::CTRL_RSVD_HI_RESET, slur_pkg::LED_MODE_RESET, slur_pkg::UNK_EN_RESET,
                slur_pkg::DRIVE_RESET_HIGH_IO, slur_pkg::CTRL_RSVD_LO_RESET,
                slur_pkg::UNK_MASK_RESET};
            strap_done <= 1'b0;
        end
        else if (do_write && wsel == 3'h1)
        begin
            // reserved bits are stored as written so read-back keeps them
            ctrl <= merge16(ctrl, w_data, w_strb) & slur_pkg::CTRL_RW_MASK;
            strap_done <= 1'b1;
        end
        else if (!strap_done)
        begin
            // a write in the first cycle wins over the strap
            ctrl[slur_pkg::DRIVE_LSB +: 2] <= strap_sync ? slur_pkg::DRIVE_RESET_LOW_IO
                : slur_pkg::DRIVE_RESET_HIGH_IO;
            strap_done <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mac_hi <= slur_pkg::MAC_HI_RESET;
            mac_mid <= slur_pkg::MAC_MID_RESET;
            mac_lo <= slur_pkg::MAC_LO_RESET;
        end
        else if (do_write)
        begin
            case (wsel)
                3'h2: mac_hi <= merge16(mac_hi, w_data, w_strb);
                3'h3: mac_mid <= merge16(mac_mid, w_data, w_strb);
                3'h4: mac_lo <= merge16(mac_lo, w_data, w_strb);
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    logic [15:0] rd_word;
    assign s_axi_arready = !s_axi_rvalid;
    always_comb
    begin
        case (reg_sel(s_axi_araddr))
            3'h1: rd_word = ctrl;
            3'h2: rd_word = mac_hi;
            3'h3: rd_word = mac_mid;
            3'h4: rd_word = mac_lo;
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= slur_pkg::AXI_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_word};
            s_axi_rresp <= (reg_sel(s_axi_araddr) == 3'h0) ? slur_pkg::AXI_SLVERR : slur_pkg::AXI_OKAY;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // configuration out to consumers
    // ----------------------------------------------------------------
    assign cfg.led_mode = ctrl[slur_pkg::LED_MODE_LSB +: 2];
    assign cfg.unk_en = ctrl[slur_pkg::UNK_EN_BIT];
    assign cfg.unk_mask = ctrl[slur_pkg::UNK_MASK_LSB +: slur_pkg::NUM_PORTS];
    assign cfg.drive = ctrl[slur_pkg::DRIVE_LSB +: 2];
    assign cfg.station_address_field = {mac_hi, mac_mid, mac_lo};

    slur_led_mux u_led
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg.user),
        .link_up(link_up),
        .speed_100(speed_100),
        .full_duplex(full_duplex),
        .activity(activity),
        .port_led_secondary_out(port_led_secondary_out),
        .port_led_primary_out(port_led_primary_out)
    );

    slur_fwd_pause u_fwd
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg.user),
        .lookup_miss(lookup_miss),
        .pause_req(pause_req),
        .unknown_fwd_ports(unknown_fwd_ports),
        .unknown_fwd_valid(unknown_fwd_valid),
        .pause_source_address(pause_source_address),
        .pause_valid(pause_valid),
        .gpio_drive_sel(gpio_drive_sel)
    );
endmodule : slur_regs

// ==== test/slur_regs_monitor.sv ====
/*
 holds bus handshake and output timing checks for the led, forwarding, drive and station address bank.
 assumes it is bound to slur_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
module slur_regs_monitor
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic io_supply_low,
    input wire logic [1:0] link_up,
    input wire logic lookup_miss,
    input wire logic pause_req,
    input wire logic [1:0] port_led_primary_out,
    input wire logic unknown_fwd_valid,
    input wire logic [47:0] pause_source_address,
    input wire logic pause_valid,
    input wire logic [1:0] gpio_drive_sel
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------------------------------------------------------------
    // bus handshakes
    // ----------------------------------------------------------------
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_wr_resp;
        s_wr_taken |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_aw_refused;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_refused: assert property (p_aw_refused) else $error("write taken during response");
    property p_rd_resp;
        s_rd_taken |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read answer late or wide");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    // ----------------------------------------------------------------
    // consumer outputs
    // ----------------------------------------------------------------
    property p_led_nolink;
        link_up == 2'b00 |=> port_led_primary_out == 2'b00;
    endproperty
    a_led_nolink: assert property (p_led_nolink) else $error("led lit without link");
    property p_unk_pulse;
        1'b1 |=> unknown_fwd_valid == $past(lookup_miss);
    endproperty
    a_unk_pulse: assert property (p_unk_pulse) else $error("forward strobe mistimed");
    property p_pause_pulse;
        pause_req |=> pause_valid;
    endproperty
    a_pause_pulse: assert property (p_pause_pulse) else $error("pause strobe missing");
    property p_pause_hold;
        !pause_req |=> $stable(pause_source_address);
    endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("pause address moved");
    // strap settles within a few cycles of release
    property p_drive_strap;
        $rose(aresetn) |-> ##4 gpio_drive_sel == (io_supply_low ? 2'h2 : 2'h1);
    endproperty
    a_drive_strap: assert property (p_drive_strap) else $error("drive reset wrong");
endmodule : slur_regs_monitor

bind slur_regs slur_regs_monitor slur_regs_monitor_i (.*);

// ==== test/slur_regs_tb.sv ====
/*
 holds the self-checking bench of the led, forwarding, drive and station address bank.
 assumes slur_regs answers on axi4-lite and the monitor is bound to it.
*/
`timescale 1ns/1ps
module slur_regs_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic io_supply_low = 1'b0;
    logic [1:0] link_up = 2'h0, speed_100 = 2'h0, full_duplex = 2'h0, activity = 2'h0;
    logic lookup_miss = 1'b0, pause_req = 1'b0;
    logic [1:0] port_led_secondary_out, port_led_primary_out, gpio_drive_sel;
    logic [2:0] unknown_fwd_ports;
    logic unknown_fwd_valid, pause_valid;
    logic [47:0] pause_source_address;
    logic [15:0] rv;
    logic [1:0] rr;
    logic [11:0] hole [2] = '{12'h044, 12'hffc};
    logic [3:0] wr_strb = 4'hf;
    int n_errors = 0;
    int n_compared = 0;

    slur_regs slur_regs_i (.*);

    initial
    begin
        forever #5 aclk = ~aclk;
    end
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    function automatic logic [15:0] ctl(input logic [1:0] m, input logic en, input logic [1:0] dr,
        input logic [2:0] mk);
        return {6'h02, m, en, dr, 2'b00, mk};
    endfunction : ctl

    function automatic logic [3:0] led_exp(input logic [1:0] m);
        logic [1:0] lact;
        lact = link_up & ~activity;
        case (m)
            2'b00: return {speed_100, lact};
            2'b01: return {activity, link_up};
            2'b10: return {full_duplex, lact};
            default: return {full_duplex, link_up};
        endcase
    endfunction : led_exp

    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] rs;
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= wr_strb;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            // sample before the edge: ready is combinational and races after it
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            rs = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            n++;
        end
        while (!tb && n < 50);
        s_axi_bready <= 1'b0;
        chk("write handshake", 1'b1, tb);
        chk("write resp", er, rs);
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [15:0] d, output logic [1:0] rs);
        logic ta, tr;
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata[15:0];
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            n++;
        end
        while (!tr && n < 50);
        s_axi_rready <= 1'b0;
        chk("read handshake", 1'b1, tr);
    endtask : rd

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [15:0] e);
        rd(a, rv, rr);
        chk(nm, e, rv);
        chk("read resp", slur_pkg::AXI_OKAY, rr);
    endtask : rd_chk

    // one-cycle pulse on the pause request or on the lookup miss
    task automatic strobe(input logic is_pause);
        @(posedge aclk);
        if (is_pause) pause_req <= 1'b1;
        else lookup_miss <= 1'b1;
        @(posedge aclk);
        pause_req <= 1'b0;
        lookup_miss <= 1'b0;
        @(negedge aclk);
    endtask : strobe

    task automatic do_reset(input logic low);
        @(posedge aclk);
        aresetn <= 1'b0;
        io_supply_low <= low;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
    endtask : do_reset

    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        logic [15:0] cv;
        do_reset(1'b0);
        chk("drive pins", 2'h1, gpio_drive_sel);
        rd_chk("ctrl", slur_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 2'h1, 3'h7));
        rd_chk("mac hi", slur_pkg::ADDR_MAC_HI, slur_pkg::MAC_HI_RESET);
        rd_chk("mac lo", slur_pkg::ADDR_MAC_LO, 16'hffff);
        link_up <= 2'b11;
        activity <= 2'b10;
        speed_100 <= 2'b01;
        full_duplex <= 2'b11;
        // every mode, drive, mask, with forwarding off and on
        for (int i = 0; i < 16; i++)
        begin
            cv = ctl(i[1:0], i[3], i[3:2], i[2:0]);
            wr(slur_pkg::ADDR_CTRL, cv, slur_pkg::AXI_OKAY);
            rd_chk("ctrl", slur_pkg::ADDR_CTRL, cv);
            strobe(1'b0);
            chk("fwd valid", 1'b1, unknown_fwd_valid);
            chk("fwd ports", i[3] ? i[2:0] : 3'h0, unknown_fwd_ports);
            chk("drive pins", i[3:2], gpio_drive_sel);
            chk("leds", led_exp(i[1:0]), {port_led_secondary_out, port_led_primary_out});
        end
        wr(slur_pkg::ADDR_MAC_HI, 16'h1234, slur_pkg::AXI_OKAY);
        wr(slur_pkg::ADDR_MAC_MID, 16'h5678, slur_pkg::AXI_OKAY);
        wr(slur_pkg::ADDR_MAC_LO, 16'h9abc, slur_pkg::AXI_OKAY);
        rd_chk("mac mid", slur_pkg::ADDR_MAC_MID, 16'h5678);
        strobe(1'b1);
        chk("pause valid", 1'b1, pause_valid);
        chk("pause address", 48'h123456789abc, pause_source_address);
        // low byte lane only: the upper byte must keep its old value
        wr_strb = 4'h1;
        wr(slur_pkg::ADDR_MAC_MID, 16'hffff, slur_pkg::AXI_OKAY);
        wr_strb = 4'hf;
        rd_chk("mac mid lane", slur_pkg::ADDR_MAC_MID, 16'h56ff);
        for (int k = 0; k < 2; k++)
        begin
            wr(hole[k], 16'h5555, slur_pkg::AXI_SLVERR);
            rd(hole[k], rv, rr);
            chk("hole data", 16'h0000, rv);
            chk("hole resp", slur_pkg::AXI_SLVERR, rr);
        end
        do_reset(1'b1);
        chk("drive pins", 2'h2, gpio_drive_sel);
        rd_chk("ctrl", slur_pkg::ADDR_CTRL, ctl(2'h0, 1'b0, 2'h2, 3'h7));
        rd_chk("mac lo", slur_pkg::ADDR_MAC_LO, 16'hffff);
        rd_chk("mac mid", slur_pkg::ADDR_MAC_MID, slur_pkg::MAC_MID_RESET);
        give_verdict();
    end

    initial
    begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        give_verdict();
    end
endmodule : slur_regs_tb
